// >>> verilog/cof_consts.svh
// constants for the channel fault flag register bank
// included by the package users; definitions only
`ifndef COF_CONSTS_SVH
`define COF_CONSTS_SVH

`define COF_CH_N            4
// register addresses on the apb slave; byte addresses except overload and open wire, which are word indices
`define COF_ADDR_CONFIG     8'h00
`define COF_ADDR_OVERLOAD   8'h04
`define COF_ADDR_OPEN_WIRE  8'h05
`define COF_ADDR_GLOBAL     8'h08
`define COF_ADDR_IRQ_STATUS 8'h0c
`define COF_ADDR_IRQ_MASK   8'h18
// values 0x04 and 0x05 are word indices, not byte offsets: byte address is four times index
`define COF_BYTE_ADDR(idx)  ((idx) << 2)
// field positions
`define COF_HI_LSB          4
`define COF_LO_LSB          0
`define COF_LATCH_BIT       0
`define COF_GLB_CL_BIT      1
`define COF_GLB_OW_BIT      2
// reset values
`define COF_FLAGS_RST       8'h00
`define COF_CONFIG_RST      8'h00
`define COF_MASK_RST        4'h0
// above-supply stretch time
`define COF_STRETCH_US      10700
`define COF_CLK_MHZ         40
`define COF_STRETCH_CYC     (`COF_STRETCH_US * `COF_CLK_MHZ)

`endif

// >>> verilog/cof_pkg.sv
// types for the channel fault flag register bank
// constants live in cof_consts.svh
package cof_pkg;
    typedef struct packed {
        logic [3:0] current_limit;
        logic [3:0] thermal_overload;
        logic [3:0] above_supply;
        logic [3:0] open_wire_offstate;
    } cof_cond_t;

    typedef struct packed {
        logic [3:0] high_side_mode;
        logic [3:0] switch_on;
    } cof_chan_mode_t;

    typedef struct packed {
        logic [7:0] overload;
        logic [7:0] open_wire;
    } cof_flags_t;
endpackage : cof_pkg

// >>> verilog/cof_flag_cell.sv
// one fault flag with real-time or latched behaviour
// cond is synchronous to pclk; rd_clr pulses on a read of its register
`timescale 1ns/1ps
module cof_flag_cell (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic latch_en,
    input  wire logic rd_clr,
    input  wire logic cond,
    // flag
    output logic      flag
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
        end else if (!latch_en) begin
            flag <= cond;
        end else if (cond) begin
            flag <= 1'b1;                       // set wins over read clear
        end else if (rd_clr) begin
            flag <= 1'b0;
        end
    end
endmodule : cof_flag_cell

// >>> verilog/cof_fault_bank.sv
// per-channel overload and open-wire fault flag registers with apb access
// fault conditions arrive synchronous to pclk from the channel analog blocks
//
// Contract
// - overload bits 7..4 flag current limiting per channel, bit 7 for channel 4.
// - overload bits 3..0 flag thermal overload per channel, bit 3 for channel 4.
// - with latch select 0 every flag except the stretched above-supply ones follows its condition in real time.
// - with latch select 1 a current-limit flag clears only on an overload read without limiting.
// - with latching a thermal flag clears on an overload read only if the overload has ended.
// - open-wire bits 7..4 flag a line above its supply, bit 7 for channel 4.
// - an above-supply flag stays set for at least the stretch time in either mode.
// - with latching, open-wire register flags clear only on its read with the fault absent.
// - open-wire bits 3..0 report open wire only for off high-side channels, else 0.
// - the global current-limit summary is the or of the four current-limit flags.
// - the global open-wire summary is the or of the four open-wire flags.
`timescale 1ns/1ps
`include "cof_consts.svh"
module cof_fault_bank (
    // apb clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // channel conditions
    input  wire cof_pkg::cof_cond_t      cond,
    input  wire cof_pkg::cof_chan_mode_t chan_mode,
    // summaries and interrupt
    output logic                        global_current_limit_summary,
    output logic                        global_open_wire_summary,
    output logic                        irq
);
    localparam int STRETCH_CYC = `COF_STRETCH_CYC;

    cof_pkg::cof_flags_t flags;
    logic [7:0]  global_config_one_reg;
    logic [3:0]  irq_status_reg;
    logic [3:0]  irq_mask_reg;
    logic [3:0]  stretch_active;
    logic [19:0] stretch_cnt [4];
    logic [3:0]  above_eff;
    logic [3:0]  ow_eff;
    logic        fault_latch_select;
    logic        acc;
    logic        rd_ovl;
    logic        rd_ow;
    logic        addr_ok;
    logic        wr;
    logic [3:0]  ev;

    function automatic logic [7:0] byte_addr(input logic [5:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

    assign fault_latch_select = global_config_one_reg[`COF_LATCH_BIT];
    assign acc    = psel && penable;
    // writes and read clears only at the completing edge of the access
    assign wr     = acc && pready && pwrite;
    assign rd_ovl = acc && pready && !pwrite && paddr == byte_addr(6'(`COF_ADDR_OVERLOAD));
    assign rd_ow  = acc && pready && !pwrite && paddr == byte_addr(6'(`COF_ADDR_OPEN_WIRE));
    assign addr_ok = paddr == `COF_ADDR_CONFIG || paddr == `COF_ADDR_GLOBAL
                  || paddr == `COF_ADDR_IRQ_STATUS || paddr == `COF_ADDR_IRQ_MASK
                  || paddr == byte_addr(6'(`COF_ADDR_OVERLOAD))
                  || paddr == byte_addr(6'(`COF_ADDR_OPEN_WIRE));

    // open wire only sensed on off high-side channels
    assign ow_eff = cond.open_wire_offstate & chan_mode.high_side_mode
                  & ~chan_mode.switch_on;

    // stretch keeps the above-supply condition alive even when it vanishes early
    genvar g;
    generate
        for (g = 0; g < `COF_CH_N; g++) begin : g_ch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stretch_cnt[g] <= 20'h00000;
                end else if (cond.above_supply[g]) begin
                    stretch_cnt[g] <= 20'(STRETCH_CYC - 1);
                end else if (stretch_cnt[g] != 20'h00000) begin
                    stretch_cnt[g] <= stretch_cnt[g] - 20'h00001;
                end
            end
            assign stretch_active[g] = stretch_cnt[g] != 20'h00000;
            assign above_eff[g] = cond.above_supply[g] | stretch_active[g];

            cof_flag_cell u_cl (
                .pclk     (pclk),
                .presetn  (presetn),
                .latch_en (fault_latch_select),
                .rd_clr   (rd_ovl && prdata[`COF_HI_LSB + g]),      // clear only what was seen
                .cond     (cond.current_limit[g]),
                .flag     (flags.overload[`COF_HI_LSB + g])
            );
            cof_flag_cell u_ot (
                .pclk     (pclk),
                .presetn  (presetn),
                .latch_en (fault_latch_select),
                .rd_clr   (rd_ovl && prdata[`COF_LO_LSB + g]),
                .cond     (cond.thermal_overload[g]),
                .flag     (flags.overload[`COF_LO_LSB + g])
            );
            cof_flag_cell u_as (
                .pclk     (pclk),
                .presetn  (presetn),
                .latch_en (fault_latch_select),
                .rd_clr   (rd_ow && prdata[`COF_HI_LSB + g]),
                .cond     (above_eff[g]),
                .flag     (flags.open_wire[`COF_HI_LSB + g])
            );
            cof_flag_cell u_ow (
                .pclk     (pclk),
                .presetn  (presetn),
                .latch_en (fault_latch_select),
                .rd_clr   (rd_ow && prdata[`COF_LO_LSB + g]),
                .cond     (ow_eff[g]),
                .flag     (flags.open_wire[`COF_LO_LSB + g])
            );
        end
    endgenerate

    // configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_config_one_reg <= `COF_CONFIG_RST;
        end else if (wr && paddr == `COF_ADDR_CONFIG) begin
            global_config_one_reg <= pwdata[7:0];
        end
    end

    // interrupt events: rising of the any-bit of each four-flag field: current limit, open wire, thermal, above supply
    logic [3:0] ev_prev;
    assign ev = {|flags.open_wire[7:4], |flags.overload[3:0],
                 |flags.open_wire[3:0], |flags.overload[7:4]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_prev <= 4'h0;
        end else begin
            ev_prev <= ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 4'h0;
        end else if (wr && paddr == `COF_ADDR_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[3:0]) | (ev & ~ev_prev);
        end else begin
            irq_status_reg <= irq_status_reg | (ev & ~ev_prev);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= `COF_MASK_RST;
        end else if (wr && paddr == `COF_ADDR_IRQ_MASK) begin
            irq_mask_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // summaries registered one cycle behind the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_current_limit_summary <= 1'b0;
            global_open_wire_summary     <= 1'b0;
        end else begin
            global_current_limit_summary <= |flags.overload[7:4];
            global_open_wire_summary     <= |flags.open_wire[3:0];
        end
    end

    // apb: setup then access; answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
        end
    end

    // read data captured in the first access cycle; the completing edge then clears
    // only flags captured as set, so a fault arriving mid-read survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && penable && !pready && !pwrite) begin
            unique case (paddr)
                `COF_ADDR_CONFIG:     prdata <= {24'h000000, global_config_one_reg};
                `COF_ADDR_GLOBAL:     prdata <= {29'h0,
                                                 global_open_wire_summary,
                                                 global_current_limit_summary, 1'b0};
                `COF_ADDR_IRQ_STATUS: prdata <= {28'h0000000, irq_status_reg};
                `COF_ADDR_IRQ_MASK:   prdata <= {28'h0000000, irq_mask_reg};
                default: begin
                    if (paddr == byte_addr(6'(`COF_ADDR_OVERLOAD))) begin
                        prdata <= {24'h000000, flags.overload};
                    end else if (paddr == byte_addr(6'(`COF_ADDR_OPEN_WIRE))) begin
                        prdata <= {24'h000000, flags.open_wire};
                    end else begin
                        prdata <= 32'h00000000;
                    end
                end
            endcase
        end
    end
endmodule : cof_fault_bank

// >>> sim/cof_fault_bank_checker.sv
// checker for the fault flag bank, bound to its top ports
// assumes one pclk domain and the apb slave timing of the bank
`timescale 1ns/1ps
module cof_fault_bank_checker (
    // clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // apb
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [7:0]              paddr,
    input wire logic [31:0]             pwdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // channels and summaries
    input wire cof_pkg::cof_cond_t      cond,
    input wire cof_pkg::cof_chan_mode_t chan_mode,
    input wire logic                    global_current_limit_summary,
    input wire logic                    global_open_wire_summary
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       latch_q;
    logic       acc;
    logic       ovl_rd;
    logic       ow_rd;
    logic [3:0] ow_live;
    assign acc = psel && penable;
    assign ovl_rd = acc && !pwrite && paddr == 8'h10;
    assign ow_rd = acc && !pwrite && paddr == 8'h14;
    // open wire only counts on off high-side channels
    assign ow_live = cond.open_wire_offstate & chan_mode.high_side_mode & ~chan_mode.switch_on;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) latch_q <= 1'b0;
        else if (acc && pready && pwrite && paddr == 8'h00) latch_q <= pwdata[0];
    end
    a_pready_answer: assert property (acc && !pready |=> pready) else $error("pready late");
    a_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_slverr_map: assert property (pready |->
        (pslverr == !(paddr inside {8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18})))
        else $error("pslverr wrong");
    a_cl_summary: assert property ((cond.current_limit != 4'h0)[*4] |->
        global_current_limit_summary) else $error("current limit summary low");
    a_ow_summary: assert property ((ow_live != 4'h0)[*4] |->
        global_open_wire_summary) else $error("open wire summary low");
    a_rt_cl_clear: assert property ((!latch_q && cond.current_limit == 4'h0)[*4] |->
        !global_current_limit_summary) else $error("current limit not cleared");
    a_rt_ow_clear: assert property ((!latch_q && ow_live == 4'h0)[*4] |->
        !global_open_wire_summary) else $error("open wire not cleared");
    a_cl_latch_hold: assert property (latch_q && $past(latch_q) &&
        global_current_limit_summary && !ovl_rd && !$past(ovl_rd) |=>
        global_current_limit_summary) else $error("latched current limit lost");
    a_ow_latch_hold: assert property (latch_q && $past(latch_q) &&
        global_open_wire_summary && !ow_rd && !$past(ow_rd) |=>
        global_open_wire_summary) else $error("latched open wire lost");
endmodule : cof_fault_bank_checker

bind cof_fault_bank cof_fault_bank_checker u_cof_fault_bank_checker (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .cond, .chan_mode,
    .global_current_limit_summary, .global_open_wire_summary);

// >>> sim/cof_apb_host.sv
// apb master model standing for the host controller
// assumes the slave answers with pready at some later rising edge
`timescale 1ns/1ps
module cof_apb_host (
    // clock
    input  wire logic        pclk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rdata;
    logic        rerr;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // request held until pready is seen at an edge, then released
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : cof_apb_host

// >>> sim/cof_fault_bank_bench.sv
// self-checking bench for the fault flag bank over apb
// drives channel conditions directly; stretch is too long to run out
`timescale 1ns/1ps
module cof_fault_bank_bench;
    logic                    pclk;
    logic                    presetn;
    cof_pkg::cof_cond_t      cond;
    cof_pkg::cof_chan_mode_t chan_mode;
    logic                    psel, penable, pwrite, pready, pslverr;
    logic [7:0]              paddr;
    logic [31:0]             pwdata, prdata;
    logic                    cl_sum, ow_sum, irq;
    int                      errors;
    int                      checks;
    cof_fault_bank u_cof_fault_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cond, .chan_mode,
        .global_current_limit_summary(cl_sum), .global_open_wire_summary(ow_sum), .irq);
    cof_apb_host u_cof_apb_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    always #12.5 pclk = ~pclk;
    task end_sim;
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task rd(input logic [7:0] a, input logic [31:0] e, input string n,
            input logic [31:0] m = '1);
        u_cof_apb_host.xfer(1'b0, a, 32'h0);
        chk(n, e, u_cof_apb_host.rdata & m);
    endtask : rd
    task settle;
        repeat (4) @(posedge pclk);
    endtask : settle
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        end_sim;
    end
    initial begin
        {pclk, presetn, cond, chan_mode, errors, checks} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h10, 32'h0, "ovl_rst");
        rd(8'h14, 32'h0, "ow_rst");
        @(posedge pclk);
        cond.current_limit <= 4'h8;
        cond.thermal_overload <= 4'h1;
        settle;
        rd(8'h10, 32'h81, "ovl_rt");
        rd(8'h08, 32'h2, "glb_cl", 32'h2);
        chk("cl_sum", 32'h1, cl_sum);
        @(posedge pclk);
        cond <= '0;
        settle;
        rd(8'h10, 32'h0, "ovl_rt_clr");
        @(posedge pclk);
        chan_mode <= 8'hf2;
        cond.open_wire_offstate <= 4'h3;
        settle;
        rd(8'h14, 32'h01, "ow_gate");
        rd(8'h08, 32'h4, "glb_ow", 32'h4);
        chk("ow_sum", 32'h1, ow_sum);
        @(posedge pclk);
        cond.open_wire_offstate <= 4'h0;
        cond.above_supply <= 4'h4;
        @(posedge pclk);
        cond.above_supply <= 4'h0;
        repeat (1000) @(posedge pclk);
        rd(8'h14, 32'h40, "as_hold");
        rd(8'h0c, 32'hf, "irq_sts", 32'hf);
        chk("irq_masked", 32'h0, irq);
        u_cof_apb_host.xfer(1'b1, 8'h18, 32'hf);
        settle;
        chk("irq_on", 32'h1, irq);
        u_cof_apb_host.xfer(1'b1, 8'h0c, 32'hf);
        settle;
        chk("irq_clr", 32'h0, irq);
        u_cof_apb_host.xfer(1'b1, 8'h00, 32'h1);
        @(posedge pclk);
        cond.current_limit <= 4'h2;
        cond.thermal_overload <= 4'h4;
        @(posedge pclk);
        cond <= '0;
        settle;
        rd(8'h10, 32'h24, "ovl_lat");
        rd(8'h10, 32'h0, "ovl_lat_clr");
        @(posedge pclk);
        cond.current_limit <= 4'h1;
        settle;
        rd(8'h10, 32'h10, "cl_held");
        rd(8'h10, 32'h10, "cl_held_again");
        @(posedge pclk);
        cond.current_limit <= 4'h0;
        cond.open_wire_offstate <= 4'h1;
        @(posedge pclk);
        cond.open_wire_offstate <= 4'h0;
        settle;
        rd(8'h14, 32'h41, "ow_lat");
        rd(8'h14, 32'h40, "as_lat");
        rd(8'h20, 32'h0, "unmapped");
        chk("slverr", 32'h1, u_cof_apb_host.rerr);
        end_sim;
    end
endmodule : cof_fault_bank_bench
